// *** bench/tb_tsf_status.sv ***
`timescale 1ns/1ps
`include "tsf_consts.svh"

module tb_tsf_status;
    // ----
    // signals
    // ----
    logic        clk = 1'b0;
    logic        arst_n, reg_wr, reg_rd, rf_tick, field_detect;
    logic        crc_start, crc_by_command, crc_finish;
    logic        timer_enable, timer_gated_mode, timer_gate, timer_expired;
    logic [5:0]  reg_addr, fifo_threshold;
    logic [7:0]  reg_wdata, reg_rdata, primary_status, d;
    logic [15:0] crc_result;
    logic [6:0]  primary_irq_request, primary_irq_enable, fifo_fill_count;
    logic [4:0]  secondary_irq_request, secondary_irq_enable;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles   = 0;
    int          fv[7]    = '{60, 59, 4, 5, 64, 0, 32};
    int          tv[7]    = '{4, 4, 4, 4, 0, 0, 63};
    int          fq[4]    = '{76, 75, 93, 94};

    always #12.5 clk = ~clk;

    tsf_status i_tsf_status (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rf_tick,
        .field_detect, .crc_start, .crc_by_command, .crc_finish, .crc_result,
        .primary_irq_request, .primary_irq_enable, .secondary_irq_request,
        .secondary_irq_enable, .timer_enable, .timer_gated_mode, .timer_gate,
        .timer_expired, .fifo_fill_count, .fifo_threshold, .primary_status
    );

    // ----
    // tasks
    // ----
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic st(input logic [7:0] m, input logic [7:0] e, input string n);
        logic [7:0] v;
        rd(`TSF_OFF_PRIMARY_STATUS, v);
        chk(n, e, v & m);
    endtask

    task automatic crc_pulse(input logic s, input logic f, input logic c, input logic [15:0] r);
        @(posedge clk);
        crc_start      <= s;
        crc_finish     <= f;
        crc_by_command <= c;
        crc_result     <= r;
        @(posedge clk);
        crc_start  <= 1'b0;
        crc_finish <= 1'b0;
    endtask

    // ticks are spread two cycles apart, well inside one gate
    task automatic freq_case(input int n);
        wr(`TSF_OFF_FREQ_CTRL, 8'h00);
        st(8'h80, 8'h00, "freq flag stopped");
        wr(`TSF_OFF_FREQ_CTRL, 8'h01);
        repeat (3) @(posedge clk);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            rf_tick <= 1'b1;
            @(posedge clk);
            rf_tick <= 1'b0;
        end
        repeat (4000) @(posedge clk);
        st(8'h80, {n * 16 > 1200 && n * 16 < 1500, 7'h00}, "freq flag");
        wr(`TSF_OFF_FREQ_COUNT, 8'hff);
        rd(`TSF_OFF_FREQ_COUNT, d);
        chk("tick count", 8'(n), d);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            $display("[FAIL] run length expected below 40000 seen %0d", cycles);
            give_verdict();
        end
    end

    // ----
    // tests
    // ----
    initial begin
        {arst_n, reg_wr, reg_rd, rf_tick, field_detect, crc_start, crc_finish} = '0;
        {crc_by_command, reg_addr, reg_wdata, crc_result} = '0;
        {primary_irq_request, primary_irq_enable, secondary_irq_request} = '0;
        {secondary_irq_enable, fifo_fill_count, fifo_threshold} = '0;
        {timer_enable, timer_gated_mode, timer_gate, timer_expired} = '0;
        repeat (2) @(posedge clk);
        #1 chk("status at reset", 8'h42, primary_status & 8'h76);
        @(posedge clk);
        arst_n <= 1'b1;
        rd(`TSF_OFF_PRIMARY_STATUS, d);
        wr(`TSF_OFF_PRIMARY_STATUS, ~d);
        st(8'h7f, d & 8'h7f, "status after write");
        rd(6'h20, d);
        chk("unmapped read", 8'h00, d);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            {secondary_irq_request, primary_irq_request} <= 12'h001 << i;
            {secondary_irq_enable, primary_irq_enable} <= 12'h001 << i;
            st(8'h10, 8'h10, "attention enabled");
            @(posedge clk);
            {secondary_irq_enable, primary_irq_enable} <= ~(12'h001 << i);
            st(8'h10, 8'h00, "attention masked");
        end
        $display("test attention done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {timer_gated_mode, timer_enable, timer_gate, timer_expired} <= 4'(i);
            st(8'h08, {4'h0, i[3] ? i[2] : i[2] & ~i[0], 3'h0}, "timer flag");
        end
        $display("test timer done");
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            fifo_fill_count <= 7'(fv[i]);
            fifo_threshold  <= 6'(tv[i]);
            st(8'h03, {6'h00, 64 - fv[i] <= tv[i], fv[i] <= tv[i]}, "fifo flags");
        end
        $display("test fifo done");
        @(posedge clk);
        field_detect <= 1'b1;
        #1 chk("field on", 8'h04, primary_status & 8'h04);
        @(posedge clk);
        field_detect <= 1'b0;
        #1 chk("field off", 8'h00, primary_status & 8'h04);
        $display("test field done");
        crc_pulse(1'b1, 1'b0, 1'b1, 16'h0000);
        st(8'h40, 8'h00, "checksum busy");
        crc_pulse(1'b0, 1'b1, 1'b1, 16'h0000);
        st(8'h60, 8'h60, "checksum good");
        crc_pulse(1'b1, 1'b0, 1'b0, 16'h0000);
        crc_pulse(1'b0, 1'b1, 1'b0, 16'h0000);
        st(8'h60, 8'h40, "checksum plain");
        crc_pulse(1'b1, 1'b0, 1'b1, 16'h0001);
        crc_pulse(1'b0, 1'b1, 1'b1, 16'h0001);
        st(8'h60, 8'h20, "checksum nonzero");
        $display("test checksum done");
        foreach (fq[i]) freq_case(fq[i]);
        $display("test frequency done");
        give_verdict();
    end
endmodule

// *** bench/tsf_status_assertions.sv ***
`timescale 1ns/1ps
`include "tsf_consts.svh"

module tsf_status_assertions
    import tsf_pkg::*;
#(
    parameter int PRI_IRQ_W = 7,
    parameter int SEC_IRQ_W = 5,
    parameter int CRC_W     = 16,
    parameter int FILL_W    = 7,
    parameter int THR_W     = 6
) (
    // clock, reset, register port
    input wire logic                   clk,
    input wire logic                   arst_n,
    input wire logic [`TSF_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    // flag sources
    input wire logic                   field_detect,
    input wire logic                   crc_start,
    input wire logic                   crc_by_command,
    input wire logic                   crc_finish,
    input wire logic [CRC_W-1:0]       crc_result,
    input wire logic [PRI_IRQ_W-1:0]   primary_irq_request,
    input wire logic [PRI_IRQ_W-1:0]   primary_irq_enable,
    input wire logic [SEC_IRQ_W-1:0]   secondary_irq_request,
    input wire logic [SEC_IRQ_W-1:0]   secondary_irq_enable,
    input wire logic                   timer_enable,
    input wire logic                   timer_gated_mode,
    input wire logic                   timer_expired,
    input wire logic [FILL_W-1:0]      fifo_fill_count,
    input wire logic [THR_W-1:0]       fifo_threshold,
    // live flags
    input wire tsf_status_t            primary_status
);
    // the edge that releases reset still loads reset values, so skip it
    logic live;
    logic att_c;
    logic tmr_c;
    logic crc_z;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end
    assign att_c = |(primary_irq_request & primary_irq_enable)
                 | |(secondary_irq_request & secondary_irq_enable);
    assign tmr_c = timer_gated_mode ? timer_enable : timer_enable & ~timer_expired;
    assign crc_z = crc_result == '0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_cmd_start;
        crc_start && crc_by_command && !crc_finish;
    endsequence
    sequence s_finish;
        crc_finish && !crc_start;
    endsequence

    a_attention_any: assert property (live |=> primary_status.attention == $past(att_c))
        else $error("attention flag wrong");
    a_timer_running: assert property (live |=> primary_status.timer_active == $past(tmr_c))
        else $error("timer flag wrong");
    a_nearly_full: assert property (live |=> primary_status.nearly_full
        == ($past(FILL_W'(64) - fifo_fill_count) <= $past(FILL_W'(fifo_threshold))))
        else $error("nearly full flag wrong");
    a_nearly_empty: assert property (live |=> primary_status.nearly_empty
        == ($past(fifo_fill_count) <= $past(FILL_W'(fifo_threshold))))
        else $error("nearly empty flag wrong");
    a_field_live: assert property (primary_status.field_present == field_detect)
        else $error("field flag not live");
    a_read_snapshot: assert property (reg_rd && reg_addr == `TSF_OFF_PRIMARY_STATUS
        |=> reg_rdata == $past(primary_status))
        else $error("status read data wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_crc_busy: assert property (live && crc_start && !crc_finish |=> !primary_status.crc_zero)
        else $error("checksum zero flag high while busy");
    a_crc_result: assert property (live ##0 s_finish |=> primary_status.crc_zero == $past(crc_z))
        else $error("checksum zero flag wrong at finish");
    a_done_set: assert property (s_cmd_start ##1 (!crc_start) [*3] ##1 s_finish
        |=> primary_status.crc_done)
        else $error("checksum done not set");
    a_done_clear: assert property (crc_start && !crc_finish |=> !primary_status.crc_done)
        else $error("checksum done not cleared by start");
endmodule

bind tsf_status tsf_status_assertions #(
    .PRI_IRQ_W(PRI_IRQ_W), .SEC_IRQ_W(SEC_IRQ_W), .CRC_W(CRC_W), .FILL_W(FILL_W), .THR_W(THR_W)
) i_tsf_status_assertions (
    .clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .field_detect, .crc_start,
    .crc_by_command, .crc_finish, .crc_result, .primary_irq_request, .primary_irq_enable,
    .secondary_irq_request, .secondary_irq_enable, .timer_enable, .timer_gated_mode,
    .timer_expired, .fifo_fill_count, .fifo_threshold, .primary_status
);

// *** hw/tsf_consts.svh ***
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TSF_ADDR_W              6
`define TSF_OFF_PRIMARY_STATUS  6'h07
`define TSF_OFF_FREQ_CTRL       6'h3c
`define TSF_OFF_FREQ_COUNT      6'h3d

// ----------------------------------------------------------------
// primary_status field positions
// ----------------------------------------------------------------
`define TSF_BIT_FREQ_OK         7
`define TSF_BIT_CRC_ZERO        6
`define TSF_BIT_CRC_DONE        5
`define TSF_BIT_ATTENTION       4
`define TSF_BIT_TIMER_ACTIVE    3
`define TSF_BIT_FIELD_PRESENT   2
`define TSF_BIT_NEARLY_FULL     1
`define TSF_BIT_NEARLY_EMPTY    0

// ----------------------------------------------------------------
// freq_ctrl fields and reset values
// ----------------------------------------------------------------
`define TSF_BIT_MEAS_EN         0
`define TSF_FREQ_CTRL_RESET     8'h01
`define TSF_STATUS_RESET        8'h42

// ----------------------------------------------------------------
// timing and frequency figures
// ----------------------------------------------------------------
`define TSF_CLK_MHZ             40
`define TSF_GATE_US             100
`define TSF_GATE_CYCLES         (`TSF_GATE_US * `TSF_CLK_MHZ)
`define TSF_FREQ_LO_MHZ         12
`define TSF_FREQ_HI_MHZ         15
`define TSF_RF_PRESCALE         16
`define TSF_FIFO_DEPTH          64

`endif

// *** hw/tsf_freq_window.sv ***
`timescale 1ns/1ps
`include "tsf_consts.svh"

module tsf_freq_window
    import tsf_pkg::*;
#(
    parameter int GATE_CYCLES = `TSF_GATE_CYCLES,
    parameter int COUNT_W     = 8
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               arst_n,
    // control and prescaled rf ticks
    input  wire logic               enable,
    input  wire logic               rf_tick,
    // result
    output logic                    freq_ok,
    output logic [COUNT_W-1:0]      last_count
);

    localparam int GW = $clog2(GATE_CYCLES + 1);
    localparam logic [GW-1:0] GATE_LAST = GW'(GATE_CYCLES - 1);
    // bounds in tick units scaled by prescale, so the strict compares stay exact
    localparam int LO_SCALED = `TSF_FREQ_LO_MHZ * `TSF_GATE_US;
    localparam int HI_SCALED = `TSF_FREQ_HI_MHZ * `TSF_GATE_US;

    tsf_fw_state_t        state;
    logic [GW-1:0]        gate_cnt;
    logic [COUNT_W-1:0]   tick_cnt;
    logic [COUNT_W-1:0]   next_ticks;
    logic                 gate_end;
    int                   scaled;

    assign gate_end = (state == TSF_FW_GATE) && (gate_cnt == GATE_LAST);
    // saturate so a wild input cannot wrap into the good band
    assign next_ticks = (rf_tick && tick_cnt != '1) ? tick_cnt + 1'b1 : tick_cnt;
    assign scaled = int'(next_ticks) * `TSF_RF_PRESCALE;

    // ----------------------------------------------------------------
    // gate sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= TSF_FW_IDLE;
            gate_cnt <= '0;
        end else begin
            case (state)
                TSF_FW_IDLE: begin
                    gate_cnt <= '0;
                    if (enable) begin
                        state <= TSF_FW_GATE;
                    end
                end
                TSF_FW_GATE: begin
                    if (!enable) begin
                        state <= TSF_FW_IDLE;
                    end
                    gate_cnt <= gate_end ? '0 : gate_cnt + 1'b1;
                end
                default: begin
                    state <= TSF_FW_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // tick counting
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
        end else if (state != TSF_FW_GATE || gate_end) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= next_ticks;
        end
    end

    // ----------------------------------------------------------------
    // verdict, held between gates
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_ok    <= 1'b0;
            last_count <= '0;
        end else if (!enable) begin
            freq_ok <= 1'b0;
        end else if (gate_end) begin
            last_count <= next_ticks;
            freq_ok    <= (scaled > LO_SCALED) && (scaled < HI_SCALED); // RULE_01
        end
    end

endmodule

// *** hw/tsf_pkg.sv ***
package tsf_pkg;

    // live flags, bit 7 first so the struct maps straight onto the register
    typedef struct packed {
        logic freq_ok;
        logic crc_zero;
        logic crc_done;
        logic attention;
        logic timer_active;
        logic field_present;
        logic nearly_full;
        logic nearly_empty;
    } tsf_status_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tsf_bus_req_t;

    typedef enum logic [0:0] {
        TSF_FW_IDLE,
        TSF_FW_GATE
    } tsf_fw_state_t;

endpackage

// *** hw/tsf_status.sv ***
`timescale 1ns/1ps
`include "tsf_consts.svh"

// What this block does
// RULE_01 - the frequency flag is set when the measured receive frequency lies strictly between 12 and 15 MHz.
// RULE_02 - in the 9-12 MHz and 15-19 MHz bands the frequency flag may read either value.
// RULE_03 - checksum_zero reads 1 for a zero checksum result, 0 while a calculation runs, 1 again on a good finish.
// RULE_04 - while a frame is sent or received checksum_zero has no meaning and software uses the error register.
// RULE_05 - checksum_done sets when a calculation started by the standalone checksum command finishes.
// RULE_06 - the attention flag reads 1 while any pending interrupt source has its enable set in either enable register.
// RULE_07 - timer_active reads 1 while the timer will decrement on its next tick.
// RULE_08 - in gated timer mode timer_active follows only the timer enable and ignores the gate.
// RULE_09 - field_present follows the field detector directly with no latching.
// RULE_10 - fifo_nearly_full reads 1 when 64 minus the fill count is at most the threshold.
// RULE_11 - fifo_nearly_empty reads 1 when the fill count is at most the threshold.
// RULE_12 - the status register resets with bits 6 and 1 at 1, bits 5, 4 and 2 at 0, bits 7, 3 and 0 free; bit 2 follows field_detect during reset.
// RULE_13 - the status register is read-only and writes to it have no effect.
module tsf_status
    import tsf_pkg::*;
#(
    parameter int PRI_IRQ_W = 7,
    parameter int SEC_IRQ_W = 5,
    parameter int CRC_W     = 16,
    parameter int FILL_W    = 7,
    parameter int THR_W     = 6,
    parameter int COUNT_W   = 8
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // register port
    input  wire logic [`TSF_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // rf front end
    input  wire logic                   rf_tick,
    input  wire logic                   field_detect,
    // checksum unit
    input  wire logic                   crc_start,
    input  wire logic                   crc_by_command,
    input  wire logic                   crc_finish,
    input  wire logic [CRC_W-1:0]       crc_result,
    // interrupt aggregator
    input  wire logic [PRI_IRQ_W-1:0]   primary_irq_request,
    input  wire logic [PRI_IRQ_W-1:0]   primary_irq_enable,
    input  wire logic [SEC_IRQ_W-1:0]   secondary_irq_request,
    input  wire logic [SEC_IRQ_W-1:0]   secondary_irq_enable,
    // timer unit
    input  wire logic                   timer_enable,
    input  wire logic                   timer_gated_mode,
    input  wire logic                   timer_gate,
    input  wire logic                   timer_expired,
    // fifo level
    input  wire logic [FILL_W-1:0]      fifo_fill_count,
    input  wire logic [THR_W-1:0]       fifo_threshold,
    // live flags for the rest of the chip
    output tsf_status_t                 primary_status
);

    localparam logic [FILL_W:0] FIFO_DEPTH = (FILL_W+1)'(`TSF_FIFO_DEPTH);
    // a constant, so the async reset branches load nothing but constants
    localparam tsf_status_t status_reset = tsf_status_t'(`TSF_STATUS_RESET);

    tsf_bus_req_t       req;
    logic [7:0]         freq_ctrl;
    logic               meas_en;
    logic               freq_ok;
    logic [COUNT_W-1:0] freq_count;
    logic               crc_busy;
    logic               crc_cmd_run;
    logic               crc_zero;
    logic               crc_done;
    logic               attention;
    logic               timer_active;
    logic               nearly_full;
    logic               nearly_empty;
    logic [FILL_W:0]    free_slots;
    logic [7:0]         next_rdata;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;
    assign meas_en = freq_ctrl[`TSF_BIT_MEAS_EN];

    // ----------------------------------------------------------------
    // frequency window
    // ----------------------------------------------------------------
    // flag is only a coarse gate count; near the band edges it can go either way
    tsf_freq_window #(
        .GATE_CYCLES (`TSF_GATE_CYCLES),
        .COUNT_W     (COUNT_W)
    ) i_tsf_freq_window (
        .clk        (clk),
        .arst_n     (arst_n),
        .enable     (meas_en),
        .rf_tick    (rf_tick),
        .freq_ok    (freq_ok),
        .last_count (freq_count)
    ); // RULE_01 RULE_02

    // ----------------------------------------------------------------
    // checksum tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_busy    <= 1'b0;
            crc_cmd_run <= 1'b0;
        end else if (crc_finish) begin
            crc_busy <= 1'b0;
        end else if (crc_start) begin
            crc_busy    <= 1'b1;
            crc_cmd_run <= crc_by_command;
        end
    end

    // no special case for frames: the value there is simply not meaningful
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_zero <= status_reset.crc_zero; // RULE_12
        end else if (crc_finish) begin
            crc_zero <= (crc_result == '0); // RULE_03
        end else if (crc_start || crc_busy) begin
            crc_zero <= 1'b0; // RULE_03 RULE_04
        end else begin
            crc_zero <= (crc_result == '0); // RULE_03
        end
    end

    // finish beats a new start in the same cycle so the event is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc_done <= status_reset.crc_done; // RULE_12
        end else if (crc_finish && crc_busy && crc_cmd_run) begin
            crc_done <= 1'b1; // RULE_05
        end else if (crc_start) begin
            crc_done <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // attention and timer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            attention <= status_reset.attention; // RULE_12
        end else begin
            attention <= |(primary_irq_request & primary_irq_enable)
                       | |(secondary_irq_request & secondary_irq_enable); // RULE_06
        end
    end

    // in gated mode the gate stalls counting but not this flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_active <= status_reset.timer_active; // RULE_12
        end else if (timer_gated_mode) begin
            timer_active <= timer_enable; // RULE_08
        end else begin
            timer_active <= timer_enable && !timer_expired && (timer_gate || !timer_gated_mode); // RULE_07
        end
    end

    // ----------------------------------------------------------------
    // fifo level compares
    // ----------------------------------------------------------------
    assign free_slots = FIFO_DEPTH - (FILL_W+1)'(fifo_fill_count);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nearly_full  <= status_reset.nearly_full;  // RULE_12
            nearly_empty <= status_reset.nearly_empty; // RULE_12
        end else begin
            nearly_full  <= free_slots <= (FILL_W+1)'(fifo_threshold); // RULE_10
            nearly_empty <= (FILL_W+1)'(fifo_fill_count) <= (FILL_W+1)'(fifo_threshold); // RULE_11
        end
    end

    // ----------------------------------------------------------------
    // flag assembly
    // ----------------------------------------------------------------
    always_comb begin
        primary_status               = '0;
        primary_status.freq_ok       = freq_ok;
        primary_status.crc_zero      = crc_zero;
        primary_status.crc_done      = crc_done;
        primary_status.attention     = attention;
        primary_status.timer_active  = timer_active;
        primary_status.field_present = field_detect; // RULE_09
        primary_status.nearly_full   = nearly_full;
        primary_status.nearly_empty  = nearly_empty;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // status address falls through the decode, so a write there changes nothing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_ctrl <= `TSF_FREQ_CTRL_RESET;
        end else if (req.wr && req.addr == `TSF_OFF_FREQ_CTRL) begin
            freq_ctrl <= {7'h00, req.wdata[`TSF_BIT_MEAS_EN]}; // RULE_13
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        case (req.addr)
            `TSF_OFF_PRIMARY_STATUS: next_rdata = primary_status; // RULE_13
            `TSF_OFF_FREQ_CTRL:      next_rdata = freq_ctrl;
            `TSF_OFF_FREQ_COUNT:     next_rdata = 8'(freq_count);
            default:                 next_rdata = 8'h00;
        endcase
    end

    // data stand one cycle only, zero otherwise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
